// *** pkg/ofh_pkg.sv ***
// package: constants, register map and state types for output fault and bridge control
// assumes a 200 MHz system clock and a millisecond time base derived from it
package ofh_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_PERIOD_NS = 1000000; // 1 ms time base
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [15:0] RETRY_MS = 16'h0004; // retry interval, ms
  localparam logic [15:0] OC_TIMEOUT_RST = 16'h01f4; // 500 ms
  localparam logic [15:0] LIM_LOW_MA = 16'h01b8; // 440 mA
  localparam logic [15:0] LIM_4A_MA = 16'h1130; // 4400 mA
  localparam logic [15:0] LIM_15A_MA = 16'h4074; // 16500 mA
  localparam logic [15:0] OC_LIMIT_RST = 16'h0000; // zero selects rating default
  localparam logic [15:0] REV_THRESH_RST = 16'h0064; // 100 mA
  localparam logic [15:0] REV_LIMIT_RST = 16'h00c8; // 200 ms
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [1:0] RATING_LOW = 2'h0;
  localparam logic [1:0] RATING_4A = 2'h1;
  localparam logic [1:0] RATING_15A = 2'h2;
  localparam logic DIAG_RST = 1'b1;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_ACTION = 8'h08;
  localparam logic [7:0] ADDR_OC_LIMIT = 8'h0c;
  localparam logic [7:0] ADDR_OC_TIMEOUT = 8'h10;
  localparam logic [7:0] ADDR_REV_THRESH = 8'h14;
  localparam logic [7:0] ADDR_REV_LIMIT = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_FAULT_VIEW = 8'h20;
  localparam logic [7:0] ADDR_USER_FAULT = 8'h24;
  // field positions
  localparam int CTRL_DIAG_BIT = 0;
  localparam int CTRL_RATING_LSB = 1;
  localparam int CTRL_ACK_BIT = 3;
  localparam int STATUS_WARN_BIT = 8;
  localparam int UF_ACT_BIT = 8;
  localparam int UF_CLR_BIT = 9;
  // fault list layout: user faults first, then device faults
  localparam int NUM_USER = 128;
  localparam int FLT_OC_FIRST = 128;
  localparam int FLT_OC_SECOND = 129;
  localparam int FLT_REV_WARN = 130;
  localparam int NUM_FLT = 131;
  localparam logic [7:0] ID_OC_FIRST = 8'hc8;
  localparam logic [7:0] ID_OC_SECOND = 8'hc9;
  localparam logic [7:0] ID_REV_WARN = 8'hca;
  localparam logic [7:0] DESC_USER = 8'h01; // warning class
  localparam logic [7:0] DESC_OC = 8'h82; // bit 7 marks shutdown class
  localparam logic [7:0] DESC_REV = 8'h03; // warning class
  typedef enum logic [1:0] {ACT_FLOAT = 2'b00, ACT_DIR_A = 2'b01, ACT_DIR_B = 2'b10,
                            ACT_BRAKE = 2'b11} bridge_action_t;
  typedef enum logic [2:0] {B_FLOAT = 3'b000, B_DIR_A = 3'b001, B_DIR_B = 3'b010,
                            B_BRAKE = 3'b011, B_REVERSE = 3'b100} bridge_state_t;
  typedef enum logic [1:0] {G_OK = 2'b00, G_OFF = 2'b01, G_ON = 2'b10,
                            G_FAULT = 2'b11} guard_state_t;
endpackage : ofh_pkg

// *** rtl/ms_tick.sv ***
// file: millisecond enable pulse divided down from the system clock
// assumes one free-running system clock
`timescale 1ns/1ps
module ms_tick #(
  parameter int CYCLES = ofh_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  output logic o_tick
);
  import ofh_pkg::*;
  logic [17:0] cnt_ff;
  logic tick_ff;
  // count one tick period, pulse for one cycle at its end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_ff <= 18'h00000;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (cnt_ff == 18'(CYCLES - 1));
      cnt_ff <= (cnt_ff == 18'(CYCLES - 1)) ? 18'h00000 : cnt_ff + 18'h00001;
    end
  end
  assign o_tick = tick_ff;
  property p_tick_single;
    @(posedge i_clk) disable iff (!i_nrst) tick_ff |=> !tick_ff;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick longer than one cycle");
endmodule : ms_tick

// *** rtl/oc_guard.sv ***
// file: per-leg overcurrent guard with timed retry and latched shutdown
// assumes a 1 ms enable tick and an overcurrent compare made by the caller
`timescale 1ns/1ps
module oc_guard (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic i_diag_en,
  input wire logic i_run,
  input wire logic i_over,
  input wire logic i_clear,
  input wire logic [15:0] i_timeout,
  output logic o_on,
  output logic o_trip,
  output ofh_pkg::guard_state_t o_state
);
  import ofh_pkg::*;
  guard_state_t state_ff, nxt_state;
  logic [15:0] phase_ff, elapsed_ff;
  logic period_end, timed_out;
  assign period_end = i_tick && (phase_ff == RETRY_MS - 16'h0001);
  assign timed_out = elapsed_ff >= i_timeout;
  // retry off/on every retry interval until current settles or time runs out
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      G_OK: if (i_diag_en && i_run && i_over) nxt_state = G_OFF;
      G_OFF:
        if (!i_diag_en) nxt_state = G_OK;
        else if (timed_out) nxt_state = G_FAULT;
        else if (period_end) nxt_state = G_ON;
      G_ON:
        if (!i_diag_en) nxt_state = G_OK;
        else if (timed_out) nxt_state = G_FAULT;
        else if (i_over) nxt_state = G_OFF;
        else if (period_end) nxt_state = G_OK;
      G_FAULT: if (i_clear && !i_over) nxt_state = G_OK;
    endcase
  end
  // state and the two ms counters
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff <= G_OK;
      phase_ff <= 16'h0000;
      elapsed_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff || state_ff == G_OK) phase_ff <= 16'h0000;
      else if (i_tick) phase_ff <= phase_ff + 16'h0001;
      if (state_ff == G_OK || state_ff == G_FAULT) elapsed_ff <= 16'h0000;
      else if (i_tick && !timed_out) elapsed_ff <= elapsed_ff + 16'h0001;
    end
  end
  assign o_on = (state_ff == G_OK) || (state_ff == G_ON);
  assign o_trip = (nxt_state == G_FAULT) && (state_ff != G_FAULT);
  assign o_state = state_ff;
  property p_retry_on;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_ff == G_OFF && i_diag_en && !timed_out && period_end) |=> (state_ff == G_ON);
  endproperty
  a_retry_on: assert property (p_retry_on) else $error("retry did not re-enable output");
  property p_timeout;
    @(posedge i_clk) disable iff (!i_nrst)
    ((state_ff == G_OFF || state_ff == G_ON) && i_diag_en && timed_out) |=> (state_ff == G_FAULT);
  endproperty
  a_timeout: assert property (p_timeout) else $error("overcurrent timeout did not shut down");
  property p_fault_hold;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_ff == G_FAULT && !(i_clear && !i_over)) |=> (state_ff == G_FAULT && !o_on);
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault left without clear");
endmodule : oc_guard

// *** rtl/output_fault_and_hbridge_ctrl.sv ***
// file: bridge pair sequencing, overcurrent protection and fault record
// assumes a plain register port and current feedback in mA per leg, synchronous to i_clk
// Contract
// - drive both legs from one state; never both switches of a leg.
// - software sets the command, then one of four bridge actions.
// - on reversal brake until both leg currents fall below threshold.
// - brake longer than the wait limit raises a warning, reversal still proceeds.
// - with diagnostics on (reset default) an overcurrent timeout holds the leg off until cleared.
// - on overcurrent switch off and retry every 4 ms until current drops; with diagnostics off the guard never switches the leg off.
// - on overcurrent timeout the leg goes off and the command becomes zero.
// - 15 A rating defaults to 16.5 A limit, 500 ms over turns off.
// - 4 A rating defaults to 4.4 A limit, 500 ms over turns off.
// - low range defaults to 440 mA limit, 500 ms over turns off.
// - one shared set of fault limits with defaults that software may overwrite.
// - show one fault at a time; acknowledge clears it and shows the next.
// - an acknowledged fault whose condition still holds stays shown.
// - 128 user fault flags that software sets and resets.
// - each user fault has a historic flag set when it goes inactive.
// - fault record holds description, fault number and active count.
// - faults are shutdown or warning class; warnings never touch drive.
`timescale 1ns/1ps
module output_fault_and_hbridge_ctrl #(
  parameter int TICK_CYCLES = ofh_pkg::TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [15:0] i_bridge_leg_first_ma,
  input wire logic [15:0] i_bridge_leg_second_ma,
  output logic o_bridge_leg_first_hs,
  output logic o_bridge_leg_first_ls,
  output logic o_bridge_leg_second_hs,
  output logic o_bridge_leg_second_ls,
  output logic [15:0] o_cmd,
  output logic o_reversal_warn
);
  import ofh_pkg::*;

  // overcurrent limit: programmed value, or the rating default when zero
  function automatic logic [15:0] eff_limit(input logic [1:0] rating, input logic [15:0] lim);
    logic [15:0] r;
    r = lim;
    if (lim == 16'h0000)
    begin
      unique case (rating)
        RATING_LOW: r = LIM_LOW_MA;
        RATING_15A: r = LIM_15A_MA;
        default: r = LIM_4A_MA;
      endcase
    end
    return r;
  endfunction : eff_limit

  // lowest pending fault: {valid, bit position}
  function automatic logic [8:0] first_pending(input logic [NUM_FLT-1:0] v);
    logic [8:0] r;
    r = 9'h000;
    for (int i = NUM_FLT - 1; i >= 0; i--)
      if (v[i]) r = {1'b1, 8'(i)};
    return r;
  endfunction : first_pending

  function automatic logic [7:0] count_ones(input logic [NUM_FLT-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < NUM_FLT; i++)
      r = r + {7'h00, v[i]};
    return r;
  endfunction : count_ones

  function automatic bridge_state_t act_state(input bridge_action_t a);
    bridge_state_t r;
    unique case (a)
      ACT_DIR_A: r = B_DIR_A;
      ACT_DIR_B: r = B_DIR_B;
      ACT_BRAKE: r = B_BRAKE;
      ACT_FLOAT: r = B_FLOAT;
    endcase
    return r;
  endfunction : act_state

  logic tick, diag_en_ff;
  logic [1:0] rating_ff;
  logic [15:0] cmd_ff, oc_limit_ff, oc_timeout_ff, limit;
  logic [15:0] reversal_current_threshold_ff, reversal_wait_limit_ff, rev_ms_ff;
  bridge_action_t bridge_action_ff;
  bridge_state_t state_ff, target_ff;
  logic warn_pulse_ff, warn_sticky_ff, first_hs_ff, first_ls_ff, second_hs_ff, second_ls_ff;
  logic [31:0] rdata_ff, read_mux;
  logic [NUM_USER-1:0] user_act_ff, user_hist_ff, user_fall, hist_clr;
  logic [6:0] user_sel_ff;
  logic [NUM_FLT-1:0] cond, cond_q_ff, pending_ff, hold, rise, clr_mask;
  logic [8:0] shown;
  logic [7:0] shown_id, shown_desc, active_cnt;
  logic wr_ctrl, wr_uf, ack, do_clr;
  logic over_first, over_second, below_both, rev_timeout, run, g1_on, g2_on, g1_trip, g2_trip;
  guard_state_t g1_state, g2_state;

  ms_tick #(.CYCLES(TICK_CYCLES)) u_tick (.i_clk(i_clk), .i_nrst(i_nrst), .o_tick(tick));

  // shared limits and current compares for both legs
  assign limit = eff_limit(rating_ff, oc_limit_ff);
  assign over_first = i_bridge_leg_first_ma > limit;
  assign over_second = i_bridge_leg_second_ma > limit;
  assign below_both = (i_bridge_leg_first_ma < reversal_current_threshold_ff) &&
                      (i_bridge_leg_second_ma < reversal_current_threshold_ff);
  assign rev_timeout = rev_ms_ff > reversal_wait_limit_ff;
  assign run = state_ff != B_FLOAT;

  oc_guard u_guard_first (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_tick(tick), .i_diag_en(diag_en_ff), .i_run(run),
    .i_over(over_first), .i_clear(do_clr && shown[7:0] == 8'(FLT_OC_FIRST)),
    .i_timeout(oc_timeout_ff), .o_on(g1_on), .o_trip(g1_trip), .o_state(g1_state));

  oc_guard u_guard_second (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_tick(tick), .i_diag_en(diag_en_ff), .i_run(run),
    .i_over(over_second), .i_clear(do_clr && shown[7:0] == 8'(FLT_OC_SECOND)),
    .i_timeout(oc_timeout_ff), .o_on(g2_on), .o_trip(g2_trip), .o_state(g2_state));

  // write decode
  assign wr_ctrl = i_wr && (i_addr == ADDR_CTRL);
  assign wr_uf = i_wr && (i_addr == ADDR_USER_FAULT);
  assign ack = wr_ctrl && i_wdata[CTRL_ACK_BIT];

  // configuration registers
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      diag_en_ff <= DIAG_RST;
      rating_ff <= RATING_4A;
      oc_limit_ff <= OC_LIMIT_RST;
      oc_timeout_ff <= OC_TIMEOUT_RST;
      reversal_current_threshold_ff <= REV_THRESH_RST;
      reversal_wait_limit_ff <= REV_LIMIT_RST;
      bridge_action_ff <= ACT_FLOAT;
    end
    else if (i_wr)
    begin
      unique case (i_addr)
        ADDR_CTRL:
        begin
          diag_en_ff <= i_wdata[CTRL_DIAG_BIT];
          rating_ff <= i_wdata[CTRL_RATING_LSB +: 2];
        end
        ADDR_ACTION: bridge_action_ff <= bridge_action_t'(i_wdata[1:0]);
        ADDR_OC_LIMIT: oc_limit_ff <= i_wdata[15:0];
        ADDR_OC_TIMEOUT: oc_timeout_ff <= i_wdata[15:0];
        ADDR_REV_THRESH: reversal_current_threshold_ff <= i_wdata[15:0];
        ADDR_REV_LIMIT: reversal_wait_limit_ff <= i_wdata[15:0];
        default: ;
      endcase
    end
  end

  // command register; a timeout shutdown forces it to zero over any write
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst) cmd_ff <= CMD_RST;
    else if (g1_trip || g2_trip) cmd_ff <= CMD_RST;
    else if (i_wr && i_addr == ADDR_CMD) cmd_ff <= i_wdata[15:0];
  end

  // bridge sequencer: one state drives both legs in step
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_ff <= B_FLOAT;
      target_ff <= B_FLOAT;
    end
    else
    begin
      unique case (state_ff)
        B_DIR_A, B_DIR_B:
          if ((state_ff == B_DIR_A && bridge_action_ff == ACT_DIR_B) ||
              (state_ff == B_DIR_B && bridge_action_ff == ACT_DIR_A))
          begin
            state_ff <= B_REVERSE;
            target_ff <= act_state(bridge_action_ff);
          end
          else state_ff <= act_state(bridge_action_ff);
        B_REVERSE:
          if (bridge_action_ff == ACT_FLOAT || bridge_action_ff == ACT_BRAKE)
            state_ff <= act_state(bridge_action_ff);
          else if (act_state(bridge_action_ff) != target_ff)
            target_ff <= act_state(bridge_action_ff);
          else if (below_both || rev_timeout) state_ff <= target_ff;
        B_FLOAT, B_BRAKE: state_ff <= act_state(bridge_action_ff);
        default: state_ff <= B_FLOAT;
      endcase
    end
  end

  // reversal brake timer and warning
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rev_ms_ff <= 16'h0000;
      warn_pulse_ff <= 1'b0;
      warn_sticky_ff <= 1'b0;
    end
    else
    begin
      if (state_ff != B_REVERSE) rev_ms_ff <= 16'h0000;
      else if (tick && !rev_timeout) rev_ms_ff <= rev_ms_ff + 16'h0001;
      warn_pulse_ff <= state_ff == B_REVERSE && act_state(bridge_action_ff) == target_ff &&
                       !below_both && rev_timeout;
      warn_sticky_ff <= warn_pulse_ff ||
                        (warn_sticky_ff && !(i_wr && i_addr == ADDR_STATUS &&
                                             i_wdata[STATUS_WARN_BIT]));
    end
  end

  // leg drive: each leg drives high or low switch, never both; guard gates the leg
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      first_hs_ff <= 1'b0;
      first_ls_ff <= 1'b0;
      second_hs_ff <= 1'b0;
      second_ls_ff <= 1'b0;
    end
    else
    begin
      first_hs_ff <= (state_ff == B_DIR_A) && g1_on;
      first_ls_ff <= (state_ff inside {B_DIR_B, B_BRAKE, B_REVERSE}) && g1_on;
      second_hs_ff <= (state_ff == B_DIR_B) && g2_on;
      second_ls_ff <= (state_ff inside {B_DIR_A, B_BRAKE, B_REVERSE}) && g2_on;
    end
  end

  // user faults with historic flags; set of a historic flag wins over its clear
  assign user_fall = cond_q_ff[NUM_USER-1:0] & ~user_act_ff;
  assign hist_clr = {{(NUM_USER-1){1'b0}}, wr_uf && i_wdata[UF_CLR_BIT]} << i_wdata[6:0];
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      user_act_ff <= {NUM_USER{1'b0}};
      user_hist_ff <= {NUM_USER{1'b0}};
      user_sel_ff <= 7'h00;
    end
    else
    begin
      if (wr_uf)
      begin
        user_sel_ff <= i_wdata[6:0];
        user_act_ff[i_wdata[6:0]] <= i_wdata[UF_ACT_BIT];
      end
      user_hist_ff <= (user_hist_ff & ~hist_clr) | user_fall;
    end
  end

  // fault record: conditions, pending list, shown entry; user faults are warnings only
  assign cond = {warn_pulse_ff, g2_state == G_FAULT, g1_state == G_FAULT, user_act_ff};
  assign hold = {1'b0, over_second, over_first, user_act_ff};
  assign rise = cond & ~cond_q_ff;
  assign shown = first_pending(pending_ff);
  assign do_clr = ack && shown[8] && !hold[shown[7:0]];
  assign clr_mask = {{(NUM_FLT-1){1'b0}}, do_clr} << shown[7:0];
  assign active_cnt = count_ones({1'b0, cond[NUM_FLT-2:0]});
  assign shown_id = !shown[8] ? 8'h00 :
                    (shown[7:0] < 8'(NUM_USER)) ? shown[7:0] + 8'h01 :
                    (shown[7:0] == 8'(FLT_OC_FIRST)) ? ID_OC_FIRST :
                    (shown[7:0] == 8'(FLT_OC_SECOND)) ? ID_OC_SECOND : ID_REV_WARN;
  assign shown_desc = !shown[8] ? 8'h00 :
                      (shown[7:0] < 8'(NUM_USER)) ? DESC_USER :
                      (shown[7:0] == 8'(FLT_REV_WARN)) ? DESC_REV : DESC_OC;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cond_q_ff <= {NUM_FLT{1'b0}};
      pending_ff <= {NUM_FLT{1'b0}};
    end
    else
    begin
      cond_q_ff <= cond;
      pending_ff <= (pending_ff & ~clr_mask) | rise;
    end
  end

  // read mux and registered read data, valid only in the cycle after the strobe
  always_comb
  begin
    read_mux = 32'h00000000;
    unique case (i_addr)
      ADDR_CTRL: read_mux = {29'h0, rating_ff, diag_en_ff};
      ADDR_CMD: read_mux = {16'h0000, cmd_ff};
      ADDR_ACTION: read_mux = {30'h0, bridge_action_ff};
      ADDR_OC_LIMIT: read_mux = {16'h0000, oc_limit_ff};
      ADDR_OC_TIMEOUT: read_mux = {16'h0000, oc_timeout_ff};
      ADDR_REV_THRESH: read_mux = {16'h0000, reversal_current_threshold_ff};
      ADDR_REV_LIMIT: read_mux = {16'h0000, reversal_wait_limit_ff};
      ADDR_STATUS: read_mux = {23'h0, warn_sticky_ff, g2_state, g1_state, 1'b0, state_ff};
      ADDR_FAULT_VIEW: read_mux = {8'h00, active_cnt, shown_desc, shown_id};
      ADDR_USER_FAULT: read_mux = {22'h0, user_hist_ff[user_sel_ff],
                                   user_act_ff[user_sel_ff], 1'b0, user_sel_ff};
      default: read_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst) rdata_ff <= 32'h00000000;
    else rdata_ff <= i_rd ? read_mux : 32'h00000000;
  end

  assign o_rdata = rdata_ff;
  assign o_bridge_leg_first_hs = first_hs_ff;
  assign o_bridge_leg_first_ls = first_ls_ff;
  assign o_bridge_leg_second_hs = second_hs_ff;
  assign o_bridge_leg_second_ls = second_ls_ff;
  assign o_cmd = cmd_ff;
  assign o_reversal_warn = warn_pulse_ff;

  property p_no_shoot_first;
    @(posedge i_clk) disable iff (!i_nrst) !(first_hs_ff && first_ls_ff);
  endproperty
  a_no_shoot_first: assert property (p_no_shoot_first) else $error("first leg shoot-through");
  property p_no_shoot_second;
    @(posedge i_clk) disable iff (!i_nrst) !(second_hs_ff && second_ls_ff);
  endproperty
  a_no_shoot_second: assert property (p_no_shoot_second) else $error("second leg shoot-through");
  property p_rev_entry;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_ff == B_DIR_A && bridge_action_ff == ACT_DIR_B) |=> (state_ff == B_REVERSE)
      ##1 (!first_hs_ff && !second_hs_ff);
  endproperty
  a_rev_entry: assert property (p_rev_entry) else $error("reversal skipped the brake");
  property p_rev_warn;
    @(posedge i_clk) disable iff (!i_nrst)
    (state_ff == B_REVERSE && act_state(bridge_action_ff) == target_ff && !below_both &&
     rev_timeout) |=> (warn_pulse_ff && state_ff == $past(target_ff));
  endproperty
  a_rev_warn: assert property (p_rev_warn) else $error("reversal timeout mishandled");
  property p_cmd_zero;
    @(posedge i_clk) disable iff (!i_nrst) (g1_trip || g2_trip) |=> (o_cmd == 16'h0000);
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command not zeroed on shutdown");
  property p_fault_off;
    @(posedge i_clk) disable iff (!i_nrst)
    (g1_state == G_FAULT) |=> (!first_hs_ff && !first_ls_ff);
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("faulted leg still driven");
  property p_ack_hold;
    @(posedge i_clk) disable iff (!i_nrst)
    (ack && shown[8] && hold[shown[7:0]]) |=> pending_ff[$past(shown[7:0])];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("held fault was cleared");
  property p_hist_set;
    @(posedge i_clk) disable iff (!i_nrst)
    (wr_uf && !i_wdata[UF_ACT_BIT] && user_act_ff[i_wdata[6:0]]) |=> ##1
      user_hist_ff[$past(i_wdata[6:0], 2)];
  endproperty
  a_hist_set: assert property (p_hist_set) else $error("historic flag not set");
endmodule : output_fault_and_hbridge_ctrl

// *** tb/load_model.sv ***
// file: load model behind the two bridge legs, returns current feedback per leg
// assumes switch pins from the controller and a load level set by the bench
`timescale 1ns/1ps
module load_model (
  input wire logic i_first_hs,
  input wire logic i_first_ls,
  input wire logic i_second_hs,
  input wire logic i_second_ls,
  input wire logic i_short,
  input wire logic [15:0] i_level_ma,
  output logic [15:0] o_first_ma,
  output logic [15:0] o_second_ma
);
  // equal legs of one rating: current flows while a switch conducts or a short holds
  assign o_first_ma = (i_first_hs | i_first_ls | i_short) ? i_level_ma : 16'h0000;
  assign o_second_ma = (i_second_hs | i_second_ls | i_short) ? i_level_ma : 16'h0000;
endmodule : load_model

// *** tb/output_fault_and_hbridge_ctrl_tb.sv ***
// file: self-checking bench for bridge sequencing and fault record
// assumes a 1 ms tick scaled to 20 clocks and the load model on the far side
`timescale 1ns/1ps
module output_fault_and_hbridge_ctrl_tb;
  import ofh_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic short_en = 1'b0;
  logic [15:0] level = 16'h0000;
  logic [31:0] o_rdata;
  logic [15:0] f_ma, s_ma, o_cmd;
  logic fhs, fls, shs, sls, warn;
  logic [3:0] act_pins [4] = '{4'h0, 4'h9, 4'h6, 4'h5};
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  // 200 MHz clock
  always #2.5 i_clk = ~i_clk;
  output_fault_and_hbridge_ctrl #(.TICK_CYCLES(20)) uut (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_bridge_leg_first_ma(f_ma), .i_bridge_leg_second_ma(s_ma),
    .o_bridge_leg_first_hs(fhs), .o_bridge_leg_first_ls(fls), .o_bridge_leg_second_hs(shs),
    .o_bridge_leg_second_ls(sls), .o_cmd(o_cmd), .o_reversal_warn(warn));
  load_model far (.i_first_hs(fhs), .i_first_ls(fls), .i_second_hs(shs), .i_second_ls(sls),
    .i_short(short_en), .i_level_ma(level), .o_first_ma(f_ma), .o_second_ma(s_ma));
  task automatic conclude();
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask : rd
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : wait_cyc
  // hang guard
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      conclude();
    end
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(ADDR_CTRL, 32'h3);
    rd(ADDR_OC_TIMEOUT, 32'h1f4);
    rd(8'h28, 32'h0);
    wr(ADDR_CMD, 32'h1234);
    for (int a = 0; a < 4; a++)
    begin
      wr(ADDR_ACTION, 32'(a));
      wait_cyc(8);
      chk({28'h0, fhs, fls, shs, sls}, {28'h0, act_pins[a]});
    end
    wr(ADDR_ACTION, 32'h1);
    level <= 16'd300;
    wr(ADDR_REV_LIMIT, 32'h2);
    wr(ADDR_ACTION, 32'h2);
    wait_cyc(6);
    chk({28'h0, fhs, fls, shs, sls}, 32'h5);
    // the warning pulse stands one cycle; look at it between edges
    for (int n = 0; n < 300 && warn !== 1'b1; n++) @(negedge i_clk);
    chk({31'h0, warn}, 32'h1);
    wait_cyc(4);
    rd(ADDR_STATUS, 32'h102);
    level <= 16'h0;
    wr(ADDR_ACTION, 32'h1);
    wr(ADDR_OC_TIMEOUT, 32'h6);
    level <= 16'd5000;
    short_en <= 1'b1;
    rd(ADDR_STATUS, 32'h151);
    wait_cyc(200);
    chk({28'h0, fhs, fls, shs, sls}, 32'h0);
    chk({16'h0, o_cmd}, 32'h0);
    rd(ADDR_FAULT_VIEW, 32'h000282c8);
    wr(ADDR_CTRL, 32'hb);
    rd(ADDR_FAULT_VIEW, 32'h000282c8);
    level <= 16'h0;
    short_en <= 1'b0;
    wr(ADDR_CTRL, 32'hb);
    rd(ADDR_FAULT_VIEW, 32'h000182c9);
    wr(ADDR_CTRL, 32'hb);
    rd(ADDR_FAULT_VIEW, 32'h000003ca);
    wr(ADDR_CTRL, 32'hb);
    rd(ADDR_FAULT_VIEW, 32'h0);
    wr(ADDR_USER_FAULT, 32'h105);
    rd(ADDR_FAULT_VIEW, 32'h00010106);
    wr(ADDR_USER_FAULT, 32'h005);
    wait_cyc(3);
    rd(ADDR_USER_FAULT, 32'h205);
    // clear the sticky warning, then trip the low range default limit
    wr(ADDR_STATUS, 32'h100);
    wr(ADDR_CTRL, 32'h1);
    level <= 16'd500;
    rd(ADDR_STATUS, 32'h051);
    conclude();
  end
endmodule : output_fault_and_hbridge_ctrl_tb
